// File: logic/pops_pkg.sv
// constants for the power-on preset selector
package pops_pkg;
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned HOLD_MS = 1000;
  localparam int unsigned HOLD_CYCLES = HOLD_MS * 1000 * CLK_MHZ;
  localparam int unsigned PRESET_W = 7;
  localparam int unsigned SW_W = 8;
  localparam int unsigned CHAN_W = 4;
  localparam int unsigned CTRL_W = 7;
  localparam int unsigned IN_CNT = 16;
  localparam int unsigned IN_W = 4;
  localparam logic [PRESET_W-1:0] PRESET_VOLUME = 7'h00;
  localparam logic [PRESET_W-1:0] PRESET_CTRL_FIRST = 7'h08;
  localparam logic [PRESET_W-1:0] PRESET_CTRL_LAST = 7'h0f;
  localparam logic [CTRL_W-1:0] CTRL_VOLUME = 7'h07;
  localparam logic [3:0] STATUS_PROG = 4'hc;
  localparam logic [CTRL_W-1:0] CTRL_ZERO = 7'h00;
  localparam logic [CHAN_W-1:0] CHAN_ZERO = 4'h0;
  typedef enum logic [1:0] {
    POPS_BOOT = 2'b00,
    POPS_RUN = 2'b01,
    POPS_HOLD = 2'b11
  } pops_state_t;
endpackage

// File: logic/pops_map.sv
// per-input message mapping of the built-in presets
`timescale 1ns/100ps
module pops_map (
  input wire logic [pops_pkg::PRESET_W-1:0] preset,
  input wire logic [pops_pkg::CHAN_W-1:0] master_chan,
  input wire logic [pops_pkg::IN_W-1:0] input_sel,
  output logic [pops_pkg::CHAN_W-1:0] out_chan,
  output logic [pops_pkg::CTRL_W-1:0] out_ctrl,
  output logic out_valid
);
  always_comb begin
    out_chan = pops_pkg::CHAN_ZERO;
    out_ctrl = pops_pkg::CTRL_ZERO;
    out_valid = 1'b0;
    if (preset == pops_pkg::PRESET_VOLUME) begin
      out_chan = input_sel; // R8
      out_ctrl = pops_pkg::CTRL_VOLUME; // R8
      out_valid = 1'b1;
    end else if (preset >= pops_pkg::PRESET_CTRL_FIRST && preset <= pops_pkg::PRESET_CTRL_LAST) begin
      out_chan = master_chan; // R6
      out_ctrl = {preset[pops_pkg::CTRL_W-pops_pkg::IN_W-1:0], input_sel}; // R7
      out_valid = 1'b1;
    end
  end
endmodule // pops_map

// File: logic/pops_top.sv
// preset selector: switch sampling, program change, hold window
// Functional notes
// R1: after power-on, sample the switch bank once and pick one of 128 presets.
// R2: the eighth switch is ignored; seven switches form the index.
// R3: switch 1 is the least significant bit, switch 7 the most.
// R4: closed switch reads one, open switch reads zero.
// R5: program change on the master channel selects the active preset.
// R6: master-channel presets send on the stored master channel; the code sends on the live master_chan input and stores no copy.
// R7: presets 8 to 15 give controllers in blocks of sixteen on master channel.
// R8: preset 0 sends volume on channels 1 to 16.
// R9: program-change preset lasts until reset; reset restores the switch preset.
// R10: after program change, indicator lit one second, all MIDI input ignored.
// R11: program number is the preset index directly.
`timescale 1ns/100ps
module pops_top #(
  parameter int unsigned HOLD_CYCLES = pops_pkg::HOLD_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [pops_pkg::SW_W-1:0] switch_on,
  input wire logic [pops_pkg::CHAN_W-1:0] master_chan,
  input wire logic msg_valid,
  input wire logic [7:0] msg_status,
  input wire logic [7:0] msg_data,
  input wire logic [pops_pkg::IN_W-1:0] input_sel,
  output logic [pops_pkg::PRESET_W-1:0] active_preset,
  output logic preset_valid,
  output logic indicator,
  output logic midi_in_enable,
  output logic [pops_pkg::CHAN_W-1:0] send_chan,
  output logic [pops_pkg::CTRL_W-1:0] send_ctrl,
  output logic send_valid
);
  pops_pkg::pops_state_t state_r, state_nxt;
  logic [pops_pkg::PRESET_W-1:0] preset_r, preset_nxt;
  logic [31:0] hold_cnt_r, hold_cnt_nxt;
  logic indicator_r, indicator_nxt;
  logic enable_r, enable_nxt;
  logic [pops_pkg::CHAN_W-1:0] chan_r, chan_nxt;
  logic [pops_pkg::CTRL_W-1:0] ctrl_r, ctrl_nxt;
  logic send_valid_r, send_valid_nxt;
  logic preset_valid_r, preset_valid_nxt;
  logic [pops_pkg::CHAN_W-1:0] map_chan;
  logic [pops_pkg::CTRL_W-1:0] map_ctrl;
  logic map_valid;
  logic prog_hit;

  function automatic logic is_prog_change(input logic [7:0] st, input logic [pops_pkg::CHAN_W-1:0] ch);
    is_prog_change = (st[$bits(st)-1:pops_pkg::CHAN_W] == pops_pkg::STATUS_PROG)
      && (st[pops_pkg::CHAN_W-1:0] == ch);
  endfunction

  assign prog_hit = msg_valid && is_prog_change(msg_status, master_chan);

  pops_map i_pops_map (
    .preset(preset_r),
    .master_chan(master_chan),
    .input_sel(input_sel),
    .out_chan(map_chan),
    .out_ctrl(map_ctrl),
    .out_valid(map_valid)
  );

  always_comb begin
    state_nxt = state_r;
    preset_nxt = preset_r;
    hold_cnt_nxt = hold_cnt_r;
    indicator_nxt = 1'b0;
    enable_nxt = 1'b0;
    case (state_r)
      pops_pkg::POPS_BOOT: begin
        preset_nxt = switch_on[pops_pkg::PRESET_W-1:0]; // R1 R2 R3 R4 R9
        state_nxt = pops_pkg::POPS_RUN;
        enable_nxt = 1'b1;
      end
      pops_pkg::POPS_RUN: begin
        enable_nxt = 1'b1;
        if (prog_hit) begin
          preset_nxt = msg_data[pops_pkg::PRESET_W-1:0]; // R5 R11
          state_nxt = pops_pkg::POPS_HOLD;
          hold_cnt_nxt = 32'h0000_0000;
          indicator_nxt = 1'b1;
          enable_nxt = 1'b0;
        end
      end
      pops_pkg::POPS_HOLD: begin
        indicator_nxt = 1'b1; // R10
        hold_cnt_nxt = hold_cnt_r + 32'h0000_0001;
        if (hold_cnt_r >= HOLD_CYCLES - 1) begin
          state_nxt = pops_pkg::POPS_RUN;
          indicator_nxt = 1'b0;
          enable_nxt = 1'b1;
        end
      end
      default: begin
        state_nxt = pops_pkg::POPS_BOOT;
      end
    endcase
    preset_valid_nxt = (state_nxt != pops_pkg::POPS_BOOT); // R1
  end

  always_comb begin
    chan_nxt = map_chan;
    ctrl_nxt = map_ctrl;
    send_valid_nxt = map_valid && (state_r != pops_pkg::POPS_BOOT);
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_r <= pops_pkg::POPS_BOOT;
      preset_r <= pops_pkg::PRESET_VOLUME;
      hold_cnt_r <= 32'h0000_0000;
      indicator_r <= 1'b0;
      enable_r <= 1'b0;
      chan_r <= pops_pkg::CHAN_ZERO;
      ctrl_r <= pops_pkg::CTRL_ZERO;
      send_valid_r <= 1'b0;
      preset_valid_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      preset_r <= preset_nxt;
      hold_cnt_r <= hold_cnt_nxt;
      indicator_r <= indicator_nxt;
      enable_r <= enable_nxt;
      chan_r <= chan_nxt;
      ctrl_r <= ctrl_nxt;
      send_valid_r <= send_valid_nxt;
      preset_valid_r <= preset_valid_nxt;
    end
  end

  assign active_preset = preset_r;
  assign preset_valid = preset_valid_r;
  assign indicator = indicator_r;
  assign midi_in_enable = enable_r;
  assign send_chan = chan_r;
  assign send_ctrl = ctrl_r;
  assign send_valid = send_valid_r;

  property p_boot_sample;
    @(posedge clk) disable iff (!reset_n)
      (state_r == pops_pkg::POPS_BOOT) |=> (preset_r == $past(switch_on[pops_pkg::PRESET_W-1:0]));
  endproperty
  a_boot_sample: assert property (p_boot_sample) else $error("switch preset not taken"); // R1

  property p_loaded_flag;
    @(posedge clk) disable iff (!reset_n)
      (state_r == pops_pkg::POPS_BOOT) |=> (preset_valid && midi_in_enable);
  endproperty
  a_loaded_flag: assert property (p_loaded_flag) else $error("preset not flagged loaded"); // R1

  property p_top_switch_ignored;
    @(posedge clk) disable iff (!reset_n)
      (state_r == pops_pkg::POPS_BOOT) |=> (active_preset == $past(switch_on[pops_pkg::PRESET_W-1:0])
        && state_r == pops_pkg::POPS_RUN);
  endproperty
  a_top_switch_ignored: assert property (p_top_switch_ignored) else $error("bad index width"); // R2

  property p_bit_order;
    @(posedge clk) disable iff (!reset_n)
      (state_r == pops_pkg::POPS_BOOT) |=> (preset_r[0] == $past(switch_on[0]));
  endproperty
  a_bit_order: assert property (p_bit_order) else $error("switch 1 not lsb"); // R3

  property p_closed_is_one;
    @(posedge clk) disable iff (!reset_n)
      (state_r == pops_pkg::POPS_BOOT)
        |=> (preset_r[pops_pkg::PRESET_W-1] == $past(switch_on[pops_pkg::PRESET_W-1]));
  endproperty
  a_closed_is_one: assert property (p_closed_is_one) else $error("switch level misread"); // R4

  property p_prog_change;
    @(posedge clk) disable iff (!reset_n)
      (state_r == pops_pkg::POPS_RUN && prog_hit)
        |=> (preset_r == $past(msg_data[pops_pkg::PRESET_W-1:0]) && indicator);
  endproperty
  a_prog_change: assert property (p_prog_change) else $error("program change missed"); // R5

  property p_prog_index;
    @(posedge clk) disable iff (!reset_n)
      (state_r == pops_pkg::POPS_RUN && prog_hit)
        |=> (active_preset == $past(msg_data[pops_pkg::PRESET_W-1:0]) && !midi_in_enable);
  endproperty
  a_prog_index: assert property (p_prog_index) else $error("program number not used as index"); // R11

  property p_master_chan;
    @(posedge clk) disable iff (!reset_n)
      (state_r != pops_pkg::POPS_BOOT && preset_r >= pops_pkg::PRESET_CTRL_FIRST
        && preset_r <= pops_pkg::PRESET_CTRL_LAST) |=> (send_chan == $past(master_chan) && send_valid);
  endproperty
  a_master_chan: assert property (p_master_chan) else $error("wrong send channel"); // R6

  property p_ctrl_block;
    @(posedge clk) disable iff (!reset_n)
      (state_r != pops_pkg::POPS_BOOT && preset_r == pops_pkg::PRESET_CTRL_FIRST)
        |=> (send_ctrl[pops_pkg::IN_W-1:0] == $past(input_sel)
          && send_ctrl[pops_pkg::CTRL_W-1:pops_pkg::IN_W] == '0);
  endproperty
  a_ctrl_block: assert property (p_ctrl_block) else $error("controller block wrong"); // R7

  property p_volume;
    @(posedge clk) disable iff (!reset_n)
      (state_r != pops_pkg::POPS_BOOT && preset_r == pops_pkg::PRESET_VOLUME)
        |=> (send_ctrl == pops_pkg::CTRL_VOLUME && send_chan == $past(input_sel) && send_valid);
  endproperty
  a_volume: assert property (p_volume) else $error("volume mapping wrong"); // R8

  property p_preset_kept;
    @(posedge clk) disable iff (!reset_n)
      (state_r != pops_pkg::POPS_BOOT && !(state_r == pops_pkg::POPS_RUN && prog_hit)) |=> $stable(preset_r);
  endproperty
  a_preset_kept: assert property (p_preset_kept) else $error("preset changed without cause"); // R9

  property p_hold_ignores;
    @(posedge clk) disable iff (!reset_n)
      (state_r == pops_pkg::POPS_HOLD && hold_cnt_r < HOLD_CYCLES - 1) |=> ($stable(preset_r) && !midi_in_enable);
  endproperty
  a_hold_ignores: assert property (p_hold_ignores) else $error("input taken during hold"); // R10

  property p_hold_release;
    @(posedge clk) disable iff (!reset_n)
      (state_r == pops_pkg::POPS_HOLD && hold_cnt_r >= HOLD_CYCLES - 1) |=> (!indicator && midi_in_enable);
  endproperty
  a_hold_release: assert property (p_hold_release) else $error("hold not released"); // R10

  property p_lit_blocks_input;
    @(posedge clk) disable iff (!reset_n)
      !(indicator && midi_in_enable);
  endproperty
  a_lit_blocks_input: assert property (p_lit_blocks_input) else $error("input open while lit"); // R10

  c_prog: cover property (@(posedge clk) disable iff (!reset_n) state_r == pops_pkg::POPS_RUN && prog_hit);
  c_hold_end: cover property (@(posedge clk) disable iff (!reset_n)
    state_r == pops_pkg::POPS_HOLD ##1 state_r == pops_pkg::POPS_RUN);
  c_ctrl: cover property (@(posedge clk) disable iff (!reset_n) send_valid && preset_r == pops_pkg::PRESET_CTRL_LAST);
  c_volume: cover property (@(posedge clk) disable iff (!reset_n)
    send_valid && preset_r == pops_pkg::PRESET_VOLUME);
endmodule // pops_top

// File: test/pops_midi_src.sv
// midi sending device model
`timescale 1ns/100ps
module pops_midi_src (
  input wire logic clk,
  output logic msg_valid,
  output logic [7:0] msg_status,
  output logic [7:0] msg_data
);
  initial begin
    msg_valid = 1'b0;
    msg_status = 8'h00;
    msg_data = 8'h00;
  end
  // one-cycle message, then lines show the inverse
  task automatic send(input logic [7:0] st, input logic [7:0] d);
    @(negedge clk);
    msg_valid = 1'b1;
    msg_status = st;
    msg_data = d;
    @(negedge clk);
    msg_valid = 1'b0;
    msg_status = ~st;
    msg_data = ~d;
  endtask
endmodule // pops_midi_src

// File: test/pops_top_test.sv
// self-checking bench for the preset selector
`timescale 1ns/100ps
module pops_top_test;
  localparam int unsigned HOLD = 20;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] switch_on = 8'h00;
  logic [3:0] master_chan = 4'h0;
  logic [3:0] input_sel = 4'h0;
  logic msg_valid, preset_valid, indicator, midi_in_enable, send_valid;
  logic [7:0] msg_status, msg_data, sw_last;
  logic [6:0] active_preset, send_ctrl, p;
  logic [3:0] send_chan;
  int num_errors = 0;
  int samples_checked = 0;
  int cnt;
  int cyc = 0;
  int t0 = 0;
  always #2 clk = ~clk;
  always @(posedge clk) cyc++;
  pops_midi_src i_pops_midi_src (.clk(clk), .msg_valid(msg_valid), .msg_status(msg_status), .msg_data(msg_data));
  pops_top #(.HOLD_CYCLES(HOLD)) i_pops_top (.clk(clk), .reset_n(reset_n), .switch_on(switch_on),
    .master_chan(master_chan), .msg_valid(msg_valid), .msg_status(msg_status), .msg_data(msg_data),
    .input_sel(input_sel), .active_preset(active_preset), .preset_valid(preset_valid), .indicator(indicator),
    .midi_in_enable(midi_in_enable), .send_chan(send_chan), .send_ctrl(send_ctrl), .send_valid(send_valid));
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  function automatic logic [11:0] exp_map(input logic [6:0] pr, input logic [3:0] m, input logic [3:0] i);
    if (pr == 7'h00) return {1'b1, 7'h07, i};
    if (pr >= 7'h08 && pr <= 7'h0f) return {1'b1, pr[2:0], i, m};
    return 12'h000;
  endfunction
  task automatic boot(input logic [7:0] sw);
    @(negedge clk);
    reset_n = 1'b0;
    switch_on = sw;
    sw_last = sw;
    p = sw[6:0];
    master_chan = 4'($urandom);
    repeat (20) @(negedge clk);
    chk("reset", {preset_valid, midi_in_enable, indicator, send_valid}, 4'h0);
    reset_n = 1'b1;
    repeat (3) @(negedge clk);
    switch_on = 8'($urandom);
    @(negedge clk);
    chk("preset", active_preset, p);
    chk("loaded", {preset_valid, midi_in_enable}, 2'b11);
  endtask
  task automatic map_all();
    for (int i = 0; i < 16; i++) begin
      input_sel = 4'(i);
      @(negedge clk);
      chk("map", send_valid ? {send_valid, send_ctrl, send_chan} : 12'h000, exp_map(p, master_chan, 4'(i)));
    end
  endtask
  task automatic prog(input logic [3:0] ch, input logic [7:0] d, input logic hit, input logic ind);
    i_pops_midi_src.send({4'hc, ch}, d);
    if (hit) t0 = cyc;
    @(negedge clk);
    if (hit) p = d[6:0];
    chk("preset", active_preset, p);
    chk("indicator", {indicator, midi_in_enable}, {ind, !ind});
  endtask
  task automatic hold_wait();
    cnt = 0;
    while (indicator === 1'b1 && cnt < 100) begin
      @(negedge clk);
      cnt++;
    end
    chk("hold", cyc - t0, HOLD);
    chk("enable", midi_in_enable, 1'b1);
  endtask
  initial begin
    void'($urandom(24554));
    boot(8'h80);
    map_all();
    for (int k = 8; k < 16; k++) begin
      boot({1'($urandom), 7'(k)});
      map_all();
    end
    repeat (5) begin
      boot(8'($urandom));
      map_all();
    end
    prog(master_chan + 4'h1, 8'h09, 1'b0, 1'b0);
    prog(master_chan, 8'h8a, 1'b1, 1'b1);
    prog(master_chan, 8'h03, 1'b0, 1'b1);
    hold_wait();
    map_all();
    prog(master_chan, 8'($urandom), 1'b1, 1'b1);
    hold_wait();
    boot(sw_last);
    stop_test();
  end
  initial begin
    #20000;
    num_errors++;
    stop_test();
  end
endmodule // pops_top_test
